// >>> logic/erfb_pkg.sv
// Purpose: Constants, register map and helpers for the embedded RAM FIFO block
// Assumes: One clock i_mclk at 250 MHz; all pins sampled on it
// Notes: Rules below bind the whole block
// Operation
// RULE1: Same-location write during an asynchronous read refreshes the read word.
// RULE2: Writes are refused while full; accepted only when not full.
// RULE3: Reads are refused while empty; accepted only when not empty.
// RULE4: Outside logic avoids access 1 ns to 3 ns after a flag-clearing strobe.
// RULE5: Reset asserts empty, clears counters, zeroes outputs, keeps memory. Equal and at-or-above flags come out high, since the threshold resets to 0.
// RULE6: Active-low pointer reset returns read and write pointers to start.
// RULE7: Three-bit depth select sets depth to two to the select plus one.
// RULE8: Eight-bit threshold gives equal flag and at-or-above flag on count.
// RULE9: Deeper than 256 the threshold doubles; at 512 equal flags at threshold plus one.
// RULE10: Nine-bit write word; parity generation replaces top bit with computed parity.
// RULE11: Parity polarity high selects odd, low selects even, both directions.
// RULE12: Read parity fault rises when the word read fails the parity check.
// RULE13: Write parity fault rises when the incoming word fails the parity check.
// RULE14: A read needs read select low and read strobe low together.
// RULE15: A write needs write select low and write strobe low together.
// RULE16: Synchronous mode times writes by write clock, reads by read clock.
// RULE17: After reset one falling write strobe edge is needed before writing.
// RULE18: Full at count equal depth, empty at zero, pointers wrap modulo depth.
package erfb_pkg;
  localparam int unsigned WORD_W = 9;
  localparam int unsigned PTR_W = 9;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned MEM_DEPTH = 512;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [CNT_W-1:0] WIDE_DEPTH = 10'h100;
  localparam logic [CNT_W-1:0] MAX_DEPTH = 10'h200;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 4'hc;

  // Control fields
  localparam int unsigned CTL_DEPTH_LSB = 0;
  localparam int unsigned CTL_ODD_BIT = 3;
  localparam int unsigned CTL_GEN_BIT = 4;
  localparam int unsigned CTL_SYNC_BIT = 5;
  localparam int unsigned CTL_THR_LSB = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0007;

  // Status and mask bits
  localparam int unsigned EV_W = 6;
  localparam int unsigned EV_WR_REFUSED = 0;
  localparam int unsigned EV_RD_REFUSED = 1;
  localparam int unsigned EV_WR_PARITY = 2;
  localparam int unsigned EV_RD_PARITY = 3;
  localparam int unsigned EV_BECAME_FULL = 4;
  localparam int unsigned EV_BECAME_EMPTY = 5;
  localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

  // Level register fields
  localparam int unsigned LVL_FULL_BIT = 16;
  localparam int unsigned LVL_EMPTY_BIT = 17;
  localparam int unsigned LVL_EQ_BIT = 18;
  localparam int unsigned LVL_GE_BIT = 19;
  localparam int unsigned LVL_ARMED_BIT = 20;

  // Timing, outside logic only
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned INDET_START_PS = 1000;
  localparam int unsigned INDET_END_PS = 3000;
  localparam int unsigned FAST_CYCLE_PS = 7500;
  localparam int unsigned INDET_END_CYC =
    (INDET_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Parity bit that makes the whole word match the selected polarity
  function automatic logic erfb_par_bit(input logic [7:0] d, input logic odd);
    erfb_par_bit = (^d) ^ odd;
  endfunction : erfb_par_bit

  function automatic logic erfb_par_ok(input logic [WORD_W-1:0] w, input logic odd);
    erfb_par_ok = ((^w) == odd);
  endfunction : erfb_par_ok

  function automatic logic [CNT_W-1:0] erfb_depth(input logic [2:0] sel);
    erfb_depth = CNT_W'(2) << sel;
  endfunction : erfb_depth

  function automatic logic [PTR_W-1:0] erfb_wrap(input logic [PTR_W-1:0] p,
                                                 input logic [CNT_W-1:0] depth);
    logic [PTR_W-1:0] mask;
    mask = PTR_W'(depth - CNT_W'(1));
    erfb_wrap = (p + PTR_W'(1)) & mask;
  endfunction : erfb_wrap
endpackage : erfb_pkg

// >>> logic/erfb_fifo.sv
// Purpose: Single-cell FIFO on a two-port RAM with flags, parity and registers
// Assumes: All pins synchronous to i_mclk; side clocks are sampled levels
// Notes: Mode, depth, threshold and parity set through the control register
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module erfb_fifo
  import erfb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ptr_reset_n,
  input wire logic i_write_side_clock,
  input wire logic i_read_side_clock,
  input wire logic i_write_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_select_n,
  input wire logic i_read_strobe_n,
  input wire logic [WORD_W-1:0] i_write_word,
  output logic [WORD_W-1:0] o_read_word,
  output logic o_full,
  output logic o_empty,
  output logic o_count_equal_flag,
  output logic o_count_at_least_flag,
  output logic o_read_parity_fault,
  output logic o_write_parity_fault,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_irq
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] ctrl_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] events;
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] depth;
  logic [CNT_W-1:0] thr_eff;
  logic [7:0] thr;
  logic par_odd;
  logic par_gen;
  logic sync_mode;
  logic wclk_q_r;
  logic rclk_q_r;
  logic wpulse_q_r;
  logic rpulse_q_r;
  logic wstrobe_q_r;
  logic armed_r;
  logic rd_active_r;
  logic write_pulse_n;
  logic read_pulse_n;
  logic wr_req;
  logic rd_req;
  logic rd_rise;
  logic push;
  logic fetch;
  logic pop;
  logic full_q_r;
  logic empty_q_r;
  logic [WORD_W-1:0] store_word;

  // RULE7: depth from select
  assign depth = erfb_depth(ctrl_r[CTL_DEPTH_LSB +: 3]);
  assign thr = ctrl_r[CTL_THR_LSB +: 8];
  assign par_odd = ctrl_r[CTL_ODD_BIT];
  assign par_gen = ctrl_r[CTL_GEN_BIT];
  assign sync_mode = ctrl_r[CTL_SYNC_BIT];

  // RULE14: read select with read strobe
  assign read_pulse_n = i_read_select_n | i_read_strobe_n;
  // RULE15: write select with write strobe
  assign write_pulse_n = i_write_select_n | i_write_strobe_n;

  // RULE16: side clocks time sync mode
  always_comb begin
    if (sync_mode) begin
      wr_req = i_write_side_clock & ~wclk_q_r & ~write_pulse_n;
      rd_req = i_read_side_clock & ~rclk_q_r & ~read_pulse_n;
      rd_rise = 1'b0;
    end else begin
      // Async write commits on the pulse's trailing edge, read starts on leading
      wr_req = write_pulse_n & ~wpulse_q_r;
      rd_req = ~read_pulse_n & rpulse_q_r;
      rd_rise = read_pulse_n & ~rpulse_q_r;
    end
  end

  // RULE18: flags from count
  assign o_full = (count_r == depth);
  assign o_empty = (count_r == '0);

  // RULE2: no write when full
  // RULE17: strobe edge arms writes
  assign push = wr_req & ~o_full & armed_r;
  // RULE3: no read when empty
  assign fetch = rd_req & ~o_empty;
  assign pop = sync_mode ? fetch : (rd_rise & rd_active_r);

  // RULE10: generated top bit
  // RULE11: polarity for generation
  assign store_word = par_gen ?
    {erfb_par_bit(i_write_word[7:0], par_odd), i_write_word[7:0]} : i_write_word;

  // RULE9: coarse threshold when deep
  assign thr_eff = (depth > WIDE_DEPTH) ? {1'b0, thr, 1'b0} : {2'b00, thr};

  // RULE8: threshold flags
  always_comb begin
    if (depth == MAX_DEPTH) begin
      // RULE9: equal one word later
      o_count_equal_flag = (count_r == thr_eff + CNT_W'(1));
    end else begin
      o_count_equal_flag = (count_r == thr_eff);
    end
    o_count_at_least_flag = (count_r >= thr_eff);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wclk_q_r <= 1'b0;
      rclk_q_r <= 1'b0;
      wpulse_q_r <= 1'b1;
      rpulse_q_r <= 1'b1;
      wstrobe_q_r <= 1'b1;
    end else begin
      wclk_q_r <= i_write_side_clock;
      rclk_q_r <= i_read_side_clock;
      wpulse_q_r <= write_pulse_n;
      rpulse_q_r <= read_pulse_n;
      wstrobe_q_r <= i_write_strobe_n;
    end
  end

  // RULE17: first falling strobe edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_r <= 1'b0;
    end else if (!i_ptr_reset_n) begin
      armed_r <= 1'b0;
    end else if (!i_write_strobe_n && wstrobe_q_r) begin
      armed_r <= 1'b1;
    end
  end

  // Memory has no reset: contents survive any reset
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= store_word;
    end
  end

  // RULE5: reset clears counters only
  // RULE6: pointer reset input
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (!i_ptr_reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      // RULE18: pointers wrap modulo depth
      if (push) begin
        wr_ptr_r <= erfb_wrap(wr_ptr_r, depth);
      end
      if (pop) begin
        rd_ptr_r <= erfb_wrap(rd_ptr_r, depth);
      end
      count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // Read word and read parity
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_read_word <= '0;
      o_read_parity_fault <= 1'b0;
      rd_active_r <= 1'b0;
    end else if (!i_ptr_reset_n) begin
      // RULE5: outputs go to zero
      o_read_word <= '0;
      o_read_parity_fault <= 1'b0;
      rd_active_r <= 1'b0;
    end else begin
      if (fetch) begin
        o_read_word <= mem[rd_ptr_r];
        // RULE12: check word read out
        o_read_parity_fault <= ~erfb_par_ok(mem[rd_ptr_r], par_odd);
      end else if (rd_active_r && push && (wr_ptr_r == rd_ptr_r)) begin
        // RULE1: refresh on same-location write
        o_read_word <= store_word;
        o_read_parity_fault <= ~erfb_par_ok(store_word, par_odd);
      end
      if (sync_mode) begin
        rd_active_r <= 1'b0;
      end else if (fetch) begin
        rd_active_r <= 1'b1;
      end else if (rd_rise) begin
        rd_active_r <= 1'b0;
      end
    end
  end

  // RULE13: incoming word check
  // RULE11: polarity for checking
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_write_parity_fault <= 1'b0;
    end else begin
      // Meaningless while generating, so held low then
      o_write_parity_fault <= ~par_gen & ~erfb_par_ok(i_write_word, par_odd);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      full_q_r <= 1'b0;
      empty_q_r <= 1'b1;
    end else begin
      full_q_r <= o_full;
      empty_q_r <= o_empty;
    end
  end

  always_comb begin
    events = '0;
    events[EV_WR_REFUSED] = wr_req & (o_full | ~armed_r);
    events[EV_RD_REFUSED] = rd_req & o_empty;
    events[EV_WR_PARITY] = wr_req & ~par_gen & ~erfb_par_ok(i_write_word, par_odd);
    events[EV_RD_PARITY] = fetch & ~erfb_par_ok(mem[rd_ptr_r], par_odd);
    events[EV_BECAME_FULL] = o_full & ~full_q_r;
    events[EV_BECAME_EMPTY] = o_empty & ~empty_q_r;
  end

  // Control and mask registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= MASK_RESET;
    end else if (i_wr) begin
      if (i_addr == OFS_CTRL) begin
        ctrl_r <= {16'h0000, i_wdata[15:8], 2'b00, i_wdata[5:0]};
      end else if (i_addr == OFS_MASK) begin
        mask_r <= i_wdata[EV_W-1:0];
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_r <= '0;
    end else if (i_wr && (i_addr == OFS_STATUS)) begin
      status_r <= (status_r & ~i_wdata[EV_W-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == OFS_CTRL) begin
        o_rdata <= ctrl_r;
      end else if (i_addr == OFS_STATUS) begin
        o_rdata <= {{(DATA_W-EV_W){1'b0}}, status_r};
      end else if (i_addr == OFS_MASK) begin
        o_rdata <= {{(DATA_W-EV_W){1'b0}}, mask_r};
      end else if (i_addr == OFS_LEVEL) begin
        o_rdata <= {11'h000, armed_r, o_count_at_least_flag, o_count_equal_flag,
                    o_empty, o_full, 6'h00, count_r};
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  assign o_irq = |(status_r & mask_r);
endmodule : erfb_fifo

// >>> bench/erfb_fifo_monitor.sv
// Purpose: Port checker for the RAM FIFO block
// Assumes: Control and mask writes are shadowed here
// Notes: Bound to every erfb_fifo instance
`timescale 1ns/1ps
module erfb_fifo_monitor
  import erfb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ptr_reset_n,
  input wire logic i_write_select_n,
  input wire logic i_read_select_n,
  input wire logic [WORD_W-1:0] i_write_word,
  input wire logic [WORD_W-1:0] o_read_word,
  input wire logic o_full,
  input wire logic o_empty,
  input wire logic o_count_equal_flag,
  input wire logic o_count_at_least_flag,
  input wire logic o_read_parity_fault,
  input wire logic o_write_parity_fault,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_irq
);
  logic [DATA_W-1:0] ctrl_r;
  logic [EV_W-1:0] mask_r;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= MASK_RESET;
    end else if (i_wr && i_addr == OFS_CTRL) begin
      ctrl_r <= i_wdata;
    end else if (i_wr && i_addr == OFS_MASK) begin
      mask_r <= i_wdata[EV_W-1:0];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  property p_eq_ge;
    o_count_equal_flag |-> o_count_at_least_flag;
  endproperty
  a_eq_ge: assert property (p_eq_ge) else $error("equal without at-least");
  property p_thr0;
    ctrl_r[CTL_THR_LSB +: 8] == 8'h00 |-> o_count_equal_flag == o_empty;
  endproperty
  a_thr0: assert property (p_thr0) else $error("zero level flag wrong");
  property p_wpe;
    !ctrl_r[CTL_GEN_BIT] |=>
      o_write_parity_fault == ((^$past(i_write_word)) != $past(ctrl_r[CTL_ODD_BIT]));
  endproperty
  a_wpe: assert property (p_wpe) else $error("write parity fault wrong");
  property p_rpe;
    $changed(o_read_word) && i_ptr_reset_n && $past(i_ptr_reset_n) && $stable(ctrl_r) |->
      o_read_parity_fault == ((^o_read_word) != ctrl_r[CTL_ODD_BIT]);
  endproperty
  a_rpe: assert property (p_rpe) else $error("read parity fault wrong");
  property p_ptr;
    !i_ptr_reset_n |=> o_empty && o_read_word == 9'h000 && !o_read_parity_fault;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer reset ignored");
  property p_full;
    o_full && i_read_select_n && $past(i_read_select_n) && $past(i_read_select_n, 2)
      && !i_wr && i_ptr_reset_n |=> o_full;
  endproperty
  a_full: assert property (p_full) else $error("full dropped without read");
  property p_empty;
    o_empty && i_write_select_n && $past(i_write_select_n) && $past(i_write_select_n, 2)
      && !i_wr && i_ptr_reset_n |=> o_empty && $stable(o_read_word);
  endproperty
  a_empty: assert property (p_empty) else $error("read taken while empty");
  property p_mask;
    mask_r == 6'h00 |-> !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt while masked");
  c_full: cover property (o_full);
  c_rpe: cover property (o_read_parity_fault);
  c_irq: cover property (o_irq);
endmodule : erfb_fifo_monitor
bind erfb_fifo erfb_fifo_monitor u_mon (.i_mclk, .i_arst_n, .i_ptr_reset_n,
  .i_write_select_n, .i_read_select_n, .i_write_word, .o_read_word, .o_full, .o_empty,
  .o_count_equal_flag, .o_count_at_least_flag, .o_read_parity_fault,
  .o_write_parity_fault, .i_addr, .i_wdata, .i_wr, .o_irq);

// >>> bench/erfb_user.sv
// Purpose: User logic driving the FIFO write and read pins
// Assumes: Asynchronous mode; each task waits an edge first
// Notes: Released write word shows the inverse of the last word
`timescale 1ns/1ps
module erfb_user
  import erfb_pkg::*;
(
  input wire logic i_mclk,
  output logic o_wsel_n,
  output logic o_wstb_n,
  output logic o_rsel_n,
  output logic o_rstb_n,
  output logic [WORD_W-1:0] o_word
);
  initial begin
    {o_wsel_n, o_wstb_n, o_rsel_n, o_rstb_n} = 4'hf;
    o_word = 9'h000;
  end
  task automatic arm();
    @(posedge i_mclk);
    o_wstb_n <= 1'b0;
    @(posedge i_mclk);
    o_wstb_n <= 1'b1;
  endtask : arm
  task automatic push(input logic [WORD_W-1:0] w);
    @(posedge i_mclk);
    o_wsel_n <= 1'b0;
    o_wstb_n <= 1'b0;
    o_word <= w;
    @(posedge i_mclk);
    o_wstb_n <= 1'b1;
    @(posedge i_mclk);
    o_wsel_n <= 1'b1;
    o_word <= ~w;
  endtask : push
  task automatic pop();
    @(posedge i_mclk);
    o_rsel_n <= 1'b0;
    o_rstb_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    o_rsel_n <= 1'b1;
    o_rstb_n <= 1'b1;
  endtask : pop
endmodule : erfb_user

// >>> bench/erfb_fifo_tb.sv
// Purpose: Self-checking bench for the RAM FIFO block
// Assumes: Both modes, queue model of stored words
// Notes: Side clocks pulse only in the synchronous scenario
`timescale 1ns/1ps
module erfb_fifo_tb import erfb_pkg::*;;
  logic i_mclk, i_arst_n, i_ptr_reset_n, i_wr, i_rd, wck, rck;
  logic ws, wt, rs, rt, full, empty, eq, ge, read_parity_fault, write_parity_fault, irq;
  logic [WORD_W-1:0] wword, rword, last;
  logic [WORD_W-1:0] q[$];
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, rdata, val;
  logic [7:0] w8;
  int err_total, comparisons, seed, depth, thr;
  erfb_user u_user (.i_mclk, .o_wsel_n(ws), .o_wstb_n(wt), .o_rsel_n(rs), .o_rstb_n(rt),
    .o_word(wword));
  erfb_fifo uut (.i_mclk, .i_arst_n, .i_ptr_reset_n, .i_write_side_clock(wck),
    .i_read_side_clock(rck), .i_write_select_n(ws), .i_write_strobe_n(wt),
    .i_read_select_n(rs), .i_read_strobe_n(rt), .i_write_word(wword), .o_read_word(rword),
    .o_full(full), .o_empty(empty), .o_count_equal_flag(eq), .o_count_at_least_flag(ge),
    .o_read_parity_fault(read_parity_fault), .o_write_parity_fault(write_parity_fault), .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata(rdata), .o_irq(irq));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    val = rdata;
  endtask : reg_rd
  task automatic side_edge(input logic wr_side);
    @(posedge i_mclk);
    if (wr_side) begin
      wck <= 1'b1;
    end else begin
      rck <= 1'b1;
    end
    @(posedge i_mclk);
    wck <= 1'b0;
    rck <= 1'b0;
  endtask : side_edge
  task automatic check_state();
    reg_rd(OFS_LEVEL);
    chk("count", val[9:0], q.size());
    chk("full", full, q.size() == depth);
    chk("empty", empty, q.size() == 0);
    chk("eq", eq, q.size() == thr);
    chk("ge", ge, q.size() >= thr);
  endtask : check_state
  task automatic put(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] kept);
    u_user.push(w);
    if (q.size() < depth) q.push_back(kept);
  endtask : put
  task automatic get();
    u_user.pop();
    if (q.size() > 0) last = q.pop_front();
    repeat (2) @(posedge i_mclk);
    #1;
    chk("word", rword, last);
  endtask : get
  initial begin
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata, wck, rck} = '0;
    i_ptr_reset_n = 1'b1;
    seed = 13;
    last = 9'h000;
    repeat (5) @(posedge i_mclk);
    chk("rst_empty", empty, 1);
    chk("rst_word", rword, 0);
    chk("rst_irq", irq, 0);
    i_arst_n <= 1'b1;
    reg_rd(OFS_CTRL);
    chk("ctrl", val, CTRL_RESET);
    reg_wr(OFS_MASK, 32'h0000_003f);
    for (int sel = 0; sel < 4; sel++) begin
      depth = 2 << sel;
      thr = sel + 1;
      reg_wr(OFS_CTRL, {16'h0000, 8'(thr), 8'(sel)});
      u_user.arm();
      for (int i = 0; i <= depth; i++) begin
        w8 = 8'($random(seed));
        put({^w8, w8}, {^w8, w8});
        check_state();
      end
      reg_rd(OFS_STATUS);
      chk("st_full", val, 32'h11);
      chk("irq", irq, 1);
      reg_wr(OFS_STATUS, 32'h0000_003f);
      for (int i = 0; i <= depth; i++) begin
        get();
        check_state();
      end
      reg_rd(OFS_STATUS);
      chk("st_empty", val, 32'h22);
      reg_wr(OFS_STATUS, 32'h0000_003f);
    end
    depth = 4;
    thr = 0;
    reg_wr(OFS_CTRL, 32'h0000_0019);
    w8 = 8'($random(seed));
    put({1'b0, w8}, {~^w8, w8});
    get();
    chk("rpe_ok", read_parity_fault, 0);
    reg_wr(OFS_CTRL, 32'h0000_0009);
    put({^w8, w8}, {^w8, w8});
    reg_rd(OFS_STATUS);
    chk("st_wpe", val, 32'h24);
    get();
    chk("rpe_bad", read_parity_fault, 1);
    put(9'h0a5, 9'h0a5);
    i_ptr_reset_n <= 1'b0;
    @(posedge i_mclk);
    i_ptr_reset_n <= 1'b1;
    q.delete();
    @(posedge i_mclk);
    #1;
    chk("ptr_empty", empty, 1);
    chk("ptr_word", rword, 0);
    reg_wr(OFS_CTRL, 32'h0000_0021);
    for (int i = 0; i < 3; i++) begin
      w8 = 8'($random(seed));
      fork
        u_user.push({^w8, w8});
        side_edge(1'b1);
      join
      // First write after pointer reset is unarmed
      if (i > 0) q.push_back({^w8, w8});
      check_state();
    end
    for (int i = 0; i < 2; i++) begin
      fork
        u_user.pop();
        side_edge(1'b0);
      join
      last = q.pop_front();
      #1;
      chk("sync_word", rword, last);
      check_state();
    end
    reg_wr(OFS_MASK, 32'h0000_0000);
    reg_rd(OFS_STATUS);
    chk("irq_masked", irq, 0);
    results();
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule : erfb_fifo_tb
